// ### core/ptoc_pkg.sv
package ptoc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned MIN_ON_MS      = 165;
    localparam int unsigned MIN_OFF_MS     = 33;
    localparam int unsigned ON_CYCLES      = MIN_ON_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned OFF_CYCLES     = MIN_OFF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TMR_W          = 26;
    localparam int unsigned SLEW_CYCLES    = 16;
    localparam int unsigned SLEW_W         = 5;
    localparam int unsigned GATE_W         = 8;
    localparam logic [GATE_W-1:0] GATE_OFF_LVL = 8'h00;
    localparam logic [GATE_W-1:0] GATE_ON_LVL  = 8'hFF;

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ON   = 5'h02,
        ST_HOLD = 5'h04,
        ST_OFF  = 5'h08,
        ST_DONE = 5'h10
    } ptoc_state_t;

endpackage

// ### core/ptoc_gate_if.sv
`timescale 1ns/1ns
interface ptoc_gate_if;
    logic                      switch_on;
    logic                      kill;
    logic [ptoc_pkg::GATE_W-1:0] level;
    logic                      at_target;
    modport ctrl  (output switch_on, output kill, input level, input at_target);
    modport drive (input switch_on, input kill, output level, output at_target);
endinterface

// ### core/ptoc_gate_slew.sv
`timescale 1ns/1ns
module ptoc_gate_slew (
    input  wire logic clk,
    input  wire logic reset,
    ptoc_gate_if.drive gif
);
    import ptoc_pkg::*;

    logic [SLEW_W-1:0] div_q;
    logic              tick;

    assign tick = (div_q == SLEW_W'(SLEW_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Equal up and down step sizes give symmetric slowed edges.
    always_ff @(posedge clk) begin
        if (reset || gif.kill) begin
            gif.level <= GATE_OFF_LVL;
        end else if (tick && gif.switch_on && gif.level != GATE_ON_LVL) begin
            gif.level <= gif.level + 1'b1;
        end else if (tick && !gif.switch_on && gif.level != GATE_OFF_LVL) begin
            gif.level <= gif.level - 1'b1;
        end
    end

    assign gif.at_target = gif.switch_on ? (gif.level == GATE_ON_LVL)
                                         : (gif.level == GATE_OFF_LVL);

endmodule // ptoc_gate_slew

// ### core/ptoc_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Enter top-off when cell first reaches regulation while charging.
// - Regulation compare is evaluated while the switch is off, and in hold while the switch is on.
// - Below regulation: switch on for at least minimum on-time.
// - Still below after on-time: stay on until regulation reached.
// - Reaching regulation after on-time: switch off for minimum off-time.
// - After off-time, switch on only if sampled cell is below regulation.
// - Minimum on-time is 165 ms.
// - Minimum off-time is 33 ms, one fifth of on-time.
// - Terminate with switch off when cell stays at regulation after off.
// - Battery removal while on turns switch off immediately.
// - Gate drive edges are slowed with equal up and down rates.
// - Input presence is monitored continuously while switch is off.
// - Input power absent while the switch is off shuts the charger down, switch off.
module ptoc_ctrl
#(
    parameter int unsigned ON_COUNT  = ptoc_pkg::ON_CYCLES,
    parameter int unsigned OFF_COUNT = ptoc_pkg::OFF_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        charging,
    input  wire logic                        cell_at_reg,
    input  wire logic                        cell_removed,
    input  wire logic                        input_present,
    output logic                             switch_on,
    output logic [ptoc_pkg::GATE_W-1:0]      gate_level,
    output logic                             topoff_active,
    output logic                             topoff_done,
    output logic                             shutdown
);
    import ptoc_pkg::*;

    // ------------------------------------------------------------------
    // State and timer
    // ------------------------------------------------------------------
    ptoc_state_t       state_q;
    logic [TMR_W-1:0]  tmr_q;
    logic              tmr_done;
    logic              sw_q;
    logic              kill_q;
    logic              off_phase;
    ptoc_state_t       tmr_state_q;
    logic              tmr_fresh;
    ptoc_gate_if       gif ();

    function automatic logic limit_hit(input logic [TMR_W-1:0] cnt,
                                       input int unsigned      lim);
        limit_hit = (cnt >= TMR_W'(lim - 1));
    endfunction

    assign off_phase = (state_q == ST_OFF) || (state_q == ST_DONE) || (state_q == ST_IDLE);

    // A state that was just entered must not read the count left by the state before it.
    // This matters after a removal, which leaves the on period part way through.
    assign tmr_fresh = (tmr_state_q != state_q);

    always_comb begin
        tmr_done = 1'b0;
        if (!tmr_fresh) begin
            case (state_q)
                ST_ON:   tmr_done = limit_hit(tmr_q, ON_COUNT);
                ST_OFF:  tmr_done = limit_hit(tmr_q, OFF_COUNT);
                default: tmr_done = 1'b0;
            endcase
        end
    end

    // Timer counts only in timed states and restarts on each state change.
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_q <= '0;
        end else if (tmr_fresh) begin
            tmr_q <= '0;
        end else if ((state_q == ST_ON || state_q == ST_OFF) && !tmr_done) begin
            tmr_q <= tmr_q + 1'b1;
        end else begin
            tmr_q <= '0;
        end
    end

    // Remembers which state the timer is counting for, so every entry restarts it.
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_state_q <= ST_IDLE;
        end else begin
            tmr_state_q <= state_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else if (off_phase && !input_present) begin
            state_q <= ST_IDLE;
        end else if (sw_q && cell_removed) begin
            state_q <= ST_OFF;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (charging && cell_at_reg) begin
                        state_q <= ST_OFF;
                    end
                end
                ST_ON: begin
                    if (tmr_done) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cell_at_reg) begin
                        state_q <= ST_OFF;
                    end
                end
                ST_OFF: begin
                    if (tmr_done) begin
                        // Sample taken with the switch off.
                        state_q <= cell_at_reg ? ST_DONE : ST_ON;
                    end
                end
                ST_DONE: begin
                    if (!charging) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_q   <= 1'b0;
            kill_q <= 1'b0;
        end else begin
            sw_q   <= (state_q == ST_ON || state_q == ST_HOLD) && !(sw_q && cell_removed);
            // The output register lags the command by one cycle, so both are watched.
            kill_q <= cell_removed && (sw_q || switch_on);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            switch_on     <= 1'b0;
            gate_level    <= GATE_OFF_LVL;
            topoff_active <= 1'b0;
            topoff_done   <= 1'b0;
            shutdown      <= 1'b1;
        end else begin
            switch_on     <= sw_q;
            gate_level    <= gif.level;
            topoff_active <= (state_q != ST_IDLE) && (state_q != ST_DONE);
            topoff_done   <= (state_q == ST_DONE);
            shutdown      <= (state_q == ST_IDLE);
        end
    end

    assign gif.switch_on = sw_q;
    assign gif.kill      = kill_q;

    ptoc_gate_slew u_slew (
        .clk   (clk),
        .reset (reset),
        .gif   (gif.drive)
    );

endmodule // ptoc_ctrl

// ### test/ptoc_cell_model.sv
`timescale 1ns/1ns
module ptoc_cell_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        surface_hi,
    input  wire logic [15:0] full,
    input  wire logic        switch_on,
    output logic             cell_at_reg
);
    logic [15:0] charge_q;
    always_ff @(posedge clk) begin
        if (clr) charge_q <= 16'h0000;
        else if (switch_on) charge_q <= charge_q + 16'h0001;
    end
    // The cell reads at regulation once full or while its surface voltage is up.
    assign cell_at_reg = surface_hi || charge_q >= full;
endmodule // ptoc_cell_model

// ### test/ptoc_checker.sv
`timescale 1ns/1ns
module ptoc_checker #(
    parameter int unsigned ON_COUNT  = 50,
    parameter int unsigned OFF_COUNT = 10
) (
    input wire logic clk, reset, charging, cell_at_reg, cell_removed, input_present,
    input wire logic switch_on, topoff_active, topoff_done, shutdown,
    input wire logic [ptoc_pkg::GATE_W-1:0] gate_level
);
    int unsigned on_q, off_q;
    logic        rm_q;
    always_ff @(posedge clk) begin
        on_q  <= (reset || !switch_on) ? 0 : on_q + 1;
        off_q <= (reset || switch_on) ? 0 : off_q + 1;
        rm_q  <= !reset && switch_on && (rm_q || cell_removed);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_dry; (!input_present && !switch_on)[*6]; endsequence
    sequence s_go;
        shutdown && input_present && charging && cell_at_reg && !topoff_done;
    endsequence
    property p_entry; s_go |-> ##[1:3] topoff_active; endproperty
    a_entry: assert property (p_entry) else $error("entry");
    property p_on; $fell(switch_on) |-> on_q >= ON_COUNT || rm_q; endproperty
    a_on: assert property (p_on) else $error("on time");
    property p_off; $rose(switch_on) |-> off_q >= OFF_COUNT; endproperty
    a_off: assert property (p_off) else $error("off time");
    property p_smp; $rose(switch_on) |-> !$past(cell_at_reg, 3); endproperty
    a_smp: assert property (p_smp) else $error("sample");
    property p_rel; $fell(switch_on) |-> $past(cell_at_reg, 3) || rm_q; endproperty
    a_rel: assert property (p_rel) else $error("release");
    property p_rmv; cell_removed && switch_on |-> ##[1:3] gate_level == 8'h00; endproperty
    a_rmv: assert property (p_rmv) else $error("removal");
    property p_dry; s_dry |-> shutdown && !topoff_active; endproperty
    a_dry: assert property (p_dry) else $error("input loss");
    // A removal may force the gate to zero in the middle of a slow step.
    property p_slew;
        !$stable(gate_level) && gate_level != 8'h00
            |=> ($stable(gate_level) || gate_level == 8'h00)[*8];
    endproperty
    a_slew: assert property (p_slew) else $error("slew");
endmodule // ptoc_checker
bind ptoc_ctrl ptoc_checker #(.ON_COUNT(ON_COUNT), .OFF_COUNT(OFF_COUNT)) u_chk (.*);

// ### test/pulsed_topoff_charge_control_tb.sv
`timescale 1ns/1ns
module pulsed_topoff_charge_control_tb;
    typedef struct {logic [15:0] full; logic [15:0] min_len;} ptoc_row_t;
    ptoc_row_t   rows [2] = '{'{16'h0014, 16'h0032}, '{16'h005A, 16'h005A}};
    logic        clk, reset, charging, cell_removed, input_present, clr, surface_hi;
    logic        cell_at_reg, switch_on, topoff_active, topoff_done, shutdown;
    logic [ptoc_pkg::GATE_W-1:0] gate_level;
    logic [15:0] full = 16'h0000, len;
    int          fail_count = 0, check_count = 0;
    ptoc_ctrl #(.ON_COUNT(50), .OFF_COUNT(10)) u_dut (.*);
    ptoc_cell_model u_cell (.*);
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++) @(negedge clk);
    endtask
    task automatic start(input logic [15:0] f);
        full = f;
        {reset, clr, charging, surface_hi} = 4'b1101;
        repeat (2) @(negedge clk);
        {reset, clr, charging} = 3'b001;
        repeat (5) @(negedge clk);
        surface_hi = 0;
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end
    initial begin
        {reset, clr, surface_hi, charging, cell_removed, input_present} = 6'b110001;
        repeat (6) @(negedge clk);
        check({switch_on, shutdown, gate_level}, 16'h0100);
        foreach (rows[i]) begin
            start(rows[i].full);
            wait_lvl(switch_on, 1'b1);
            for (len = 0; switch_on === 1'b1 && len < 16'h0190; len++) @(negedge clk);
            wait_lvl(topoff_done, 1'b1);
            check({15'h0000, len >= rows[i].min_len}, 16'h0001);
            check({topoff_done, switch_on}, 16'h0002);
        end
        start(16'h00C8);
        wait_lvl(switch_on, 1'b1);
        repeat (40) @(negedge clk);
        cell_removed = 1;
        repeat (4) @(negedge clk);
        check({switch_on, gate_level}, 16'h0000);
        cell_removed = 0;
        // A removal restarts the whole off period before the switch may close again.
        for (len = 0; switch_on !== 1'b1 && len < 16'h0190; len++) @(negedge clk);
        check({15'h0000, len >= 16'h000A}, 16'h0001);
        check(switch_on, 16'h0001);
        start(16'h00C8);
        input_present = 0;
        repeat (10) @(negedge clk);
        check({shutdown, topoff_active, switch_on}, 16'h0004);
        report_and_stop;
    end
endmodule // pulsed_topoff_charge_control_tb
